// ==== common/lowpower_pkg.sv ====
// Shared constants of the always-on timer and power sequencer
// Assumes a 32-bit APB with byte addresses and a 250 MHz pclk
package lowpower_pkg;
	localparam int          APB_AW         = 12;
	localparam int          GPIO_N         = 17;
	localparam int          WAKE_GPIO_N    = 16;
	localparam int          WDOG_W         = 15;
	localparam int          SYNC_W         = 22;
	// Register byte offsets
	localparam logic [11:0] REG_CTRL       = 12'h000;
	localparam logic [11:0] REG_WDOG_KICK  = 12'h004;
	localparam logic [11:0] REG_CAL_DIV    = 12'h008;
	localparam logic [11:0] REG_SLEEP_CNT  = 12'h00c;
	localparam logic [11:0] REG_CMP_A      = 12'h010;
	localparam logic [11:0] REG_CMP_B      = 12'h014;
	localparam logic [11:0] REG_STATUS     = 12'h018;
	localparam logic [11:0] REG_WAKE_MASK  = 12'h01c;
	localparam logic [11:0] REG_POWER      = 12'h020;
	localparam logic [11:0] REG_WAKE_CAUSE = 12'h024;
	// Control fields
	localparam int          CTRL_WDOG_EN   = 0;
	localparam int          CTRL_CLK_SEL   = 1;
	localparam int          CTRL_DIV_LSB   = 2;
	localparam int          CTRL_SER_WAKE  = 6;
	// Status, wake cause and power fields
	localparam int          ST_CMP_A       = 0;
	localparam int          ST_CMP_B       = 1;
	localparam int          ST_WDOG_WARN   = 2;
	localparam int          ST_WDOG_RESET  = 3;
	localparam int          WK_CMP_A       = 0;
	localparam int          WK_EXT_IRQ     = 1;
	localparam int          WK_DEBUG       = 2;
	localparam int          WK_SERIAL      = 3;
	localparam int          WK_GPIO        = 4;
	localparam int          PWR_IDLE       = 0;
	localparam int          PWR_DEEP       = 1;
	// Reset values and timing
	localparam logic [7:0]  CAL_DIV_RST    = 8'h0a;
	localparam logic [3:0]  PRESCALE_MAX   = 4'ha;
	localparam int          RC_FREQ_HZ     = 10000;
	localparam int          WDOG_TIMEOUT_MS = 2000;
	localparam int          WDOG_WARN_MS   = 1750;
	localparam int          WDOG_TIMEOUT_TICKS = WDOG_TIMEOUT_MS * RC_FREQ_HZ / 1000;
	localparam int          WDOG_WARN_TICKS = WDOG_WARN_MS * RC_FREQ_HZ / 1000;
	localparam int          PCLK_PERIOD_NS = 4;
	localparam int          RST_PULSE_NS   = 64;
	localparam logic [4:0]  RST_PULSE_CYC  = 5'((RST_PULSE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS);

	typedef enum logic [5:0] {
		PM_ACTIVE  = 6'b000001,
		PM_IDLE    = 6'b000010,
		PM_SAVE    = 6'b000100,
		PM_SLEEP   = 6'b001000,
		PM_REG_UP  = 6'b010000,
		PM_RESTORE = 6'b100000
	} pmode_t;
endpackage

// ==== design/tick_divider.sv ====
// Programmable divider of an enable pulse stream
// Assumes tick_in is a one-cycle pulse on pclk
`timescale 1ns/1ns
module tick_divider #(
	parameter int WIDTH = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             tick_in,
	input  wire logic [WIDTH-1:0] div,
	output logic                  tick_out
);
	logic [WIDTH-1:0] cnt_ff;
	logic [WIDTH-1:0] nxt_cnt;
	wire              last;

	if (WIDTH < 2) begin : g_bad_width
		$error("tick_divider needs WIDTH of at least 2");
	end

	// Zero acts as one so the output never stalls
	assign last    = tick_in && (({1'b0, cnt_ff} + 1'b1) >= {1'b0, div});
	assign nxt_cnt = last ? '0 : (tick_in ? cnt_ff + 1'b1 : cnt_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff   <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt_ff   <= nxt_cnt;
			tick_out <= last;
		end
	end
endmodule

// ==== design/aon_timer_power.sv ====
// Always-on sleep timer, watchdog and power mode sequencer with APB slave
// Assumes pclk stays alive in deep sleep; oscillators and pins arrive asynchronous
`timescale 1ns/1ns
// Functional notes
// - RC clock divided to calibrated 1kHz tick
// - Watchdog on RC clock, reset disabled, software-enabled
// - Watchdog timeout about 2 s resets chip
// - Warning interrupt about 1.75 s after restart
// - 16-bit sleep counter in always-on logic
// - Two compare channels, each with interrupt
// - Only compare A requests wake
// - Select 0 calibrated clock, 1 crystal
// - Prescale 2^N, N above 10 acts as 10
// - Sleep counter wraps to zero
// - Active, idle and deep sleep modes
// - Deep sleep left on five wake sources
// - Serial receiver off until wake completes
// - Regulator off in deep sleep, on at wake
// - GPIO outputs frozen during deep sleep
// - Core domain loses state in deep sleep
// - CPU context saved and restored by hardware
// - Wake cause and later events recorded
// - Masked low 16 GPIO changes wake
// - Watchdog reset logged for software
module aon_timer_power #(
	parameter int unsigned WDOG_TIMEOUT_TICKS = lowpower_pkg::WDOG_TIMEOUT_TICKS,
	parameter int unsigned WDOG_WARN_TICKS    = lowpower_pkg::WDOG_WARN_TICKS
) (
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [lowpower_pkg::APB_AW-1:0]        paddr,
	input  wire logic [31:0]                            pwdata,
	output logic                                        pready,
	output logic [31:0]                                 prdata,
	output logic                                        pslverr,
	input  wire logic                                   rc_osc_in,
	input  wire logic                                   low_freq_osc_input,
	input  wire logic                                   ext_irq,
	input  wire logic                                   debug_serial_port,
	input  wire logic                                   serial_activity,
	input  wire logic                                   regulator_ready,
	input  wire logic [lowpower_pkg::GPIO_N-1:0]        gpio_in,
	input  wire logic [lowpower_pkg::GPIO_N-1:0]        gpio_out_core,
	input  wire logic                                   cpu_irq,
	input  wire logic                                   ctx_save_done,
	input  wire logic                                   ctx_restore_done,
	output logic [lowpower_pkg::GPIO_N-1:0]             gpio_out_pad,
	output logic                                        gpio_frozen,
	output logic                                        cmp_a_irq,
	output logic                                        cmp_b_irq,
	output logic                                        wdog_warn_irq,
	output logic                                        sleep_wake_req,
	output logic                                        chip_reset,
	output logic                                        cpu_halt,
	output logic                                        ctx_save_req,
	output logic                                        ctx_restore_req,
	output logic                                        core_reset_n,
	output logic                                        regulator_enable,
	output logic                                        regulator_output_pin,
	output logic                                        serial_rx_enable
);
	import lowpower_pkg::*;

	if (WDOG_WARN_TICKS == 0 || WDOG_WARN_TICKS >= WDOG_TIMEOUT_TICKS ||
	    WDOG_TIMEOUT_TICKS >= (1 << WDOG_W)) begin : g_bad_wdog
		$error("watchdog tick counts out of range");
	end

	localparam logic [WDOG_W-1:0] WARN_LAST = WDOG_W'(WDOG_WARN_TICKS - 1);
	localparam logic [WDOG_W-1:0] TO_LAST   = WDOG_W'(WDOG_TIMEOUT_TICKS - 1);

	function automatic logic [9:0] div_mask(input logic [3:0] n);
		logic [9:0] m;
		m = (n > PRESCALE_MAX) ? 10'h3ff : 10'((11'h001 << n) - 11'h001);
		return m;
	endfunction

	// Synchronisers: gpio[15:0], rc 16, lf 17, ext 18, dbg 19, serial 20, reg 21
	logic [SYNC_W-1:0]      sync1_ff;
	logic [SYNC_W-1:0]      sync2_ff;
	logic [17:0]            prev_ff;
	logic                   wdog_en_ff;
	logic                   clk_sel_ff;
	logic [3:0]             clk_div_ff;
	logic                   ser_wake_en_ff;
	logic [7:0]             cal_div_ff;
	logic [9:0]             pre_cnt_ff;
	logic [15:0]            sleep_cnt_ff;
	logic [15:0]            cmp_a_ff;
	logic [15:0]            cmp_b_ff;
	logic [WAKE_GPIO_N-1:0] wake_mask_ff;
	logic [WDOG_W-1:0]      wdog_cnt_ff;
	logic [4:0]             rst_cnt_ff;
	logic [3:0]             stat_ff;
	logic [4:0]             wake_cause_ff;
	pmode_t                 mode_ff;
	pmode_t                 nxt_mode;

	wire        rc_tick;
	wire        lf_tick;
	wire        cal_tick;
	wire        src_tick;
	wire        pre_tick;
	wire [9:0]  mask;
	wire [15:0] nxt_sleep_cnt;
	wire        cmp_a_evt;
	wire        cmp_b_evt;
	wire        wd_step;
	wire        warn_evt;
	wire        to_evt;
	wire        gpio_chg;
	wire        ser_wake;
	wire        wake_any;
	wire        in_wake;
	wire        nxt_freeze;
	wire        access;
	wire        setup_done;
	wire        wr_fire;
	wire        hit;
	wire [31:0] rd_data;
	wire [31:0] ctrl_rd;
	wire [3:0]  stat_set;
	wire [4:0]  wake_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			prev_ff  <= '0;
		end else begin
			sync1_ff <= {regulator_ready, serial_activity, debug_serial_port, ext_irq,
			             low_freq_osc_input, rc_osc_in, gpio_in[WAKE_GPIO_N-1:0]};
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff[17:0];
		end
	end

	assign rc_tick  = sync2_ff[16] & ~prev_ff[16];
	assign lf_tick  = sync2_ff[17] & ~prev_ff[17];
	assign gpio_chg = |((sync2_ff[15:0] ^ prev_ff[15:0]) & wake_mask_ff);
	assign ser_wake = sync2_ff[20] & ser_wake_en_ff;

	tick_divider #(
		.WIDTH    (8)
	) u_cal_div (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick_in  (rc_tick),
		.div      (cal_div_ff),
		.tick_out (cal_tick)
	);

	// Sleep timer path
	assign src_tick      = clk_sel_ff ? lf_tick : cal_tick;
	assign mask          = div_mask(clk_div_ff);
	assign pre_tick      = src_tick && ((pre_cnt_ff & mask) == mask);
	assign nxt_sleep_cnt = sleep_cnt_ff + 16'h0001;
	assign cmp_a_evt     = pre_tick && (nxt_sleep_cnt == cmp_a_ff);
	assign cmp_b_evt     = pre_tick && (nxt_sleep_cnt == cmp_b_ff);

	// Watchdog path
	assign wd_step  = wdog_en_ff && rc_tick;
	assign warn_evt = wd_step && (wdog_cnt_ff == WARN_LAST);
	assign to_evt   = wd_step && (wdog_cnt_ff == TO_LAST);

	// APB: access lasts two cycles, the write lands with pready
	assign access     = psel && penable;
	assign setup_done = access && !pready;
	assign wr_fire    = access && pwrite && pready;
	assign hit = (paddr == REG_CTRL) || (paddr == REG_WDOG_KICK) || (paddr == REG_CAL_DIV) ||
	             (paddr == REG_SLEEP_CNT) || (paddr == REG_CMP_A) || (paddr == REG_CMP_B) ||
	             (paddr == REG_STATUS) || (paddr == REG_WAKE_MASK) || (paddr == REG_POWER) ||
	             (paddr == REG_WAKE_CAUSE);

	assign ctrl_rd[CTRL_WDOG_EN]                   = wdog_en_ff;
	assign ctrl_rd[CTRL_CLK_SEL]                   = clk_sel_ff;
	assign ctrl_rd[CTRL_DIV_LSB+3:CTRL_DIV_LSB]    = clk_div_ff;
	assign ctrl_rd[CTRL_SER_WAKE]                  = ser_wake_en_ff;
	assign ctrl_rd[31:CTRL_SER_WAKE+1]             = '0;

	assign rd_data = (paddr == REG_CTRL)       ? ctrl_rd :
	                 (paddr == REG_CAL_DIV)    ? {24'h000000, cal_div_ff} :
	                 (paddr == REG_SLEEP_CNT)  ? {16'h0000, sleep_cnt_ff} :
	                 (paddr == REG_CMP_A)      ? {16'h0000, cmp_a_ff} :
	                 (paddr == REG_CMP_B)      ? {16'h0000, cmp_b_ff} :
	                 (paddr == REG_STATUS)     ? {28'h0000000, stat_ff} :
	                 (paddr == REG_WAKE_MASK)  ? {16'h0000, wake_mask_ff} :
	                 (paddr == REG_POWER)      ? {26'h0000000, mode_ff} :
	                 (paddr == REG_WAKE_CAUSE) ? {27'h0000000, wake_cause_ff} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_done;
			prdata  <= setup_done ? rd_data : 32'h00000000;
			pslverr <= setup_done && !hit;
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_en_ff     <= 1'b0;
			clk_sel_ff     <= 1'b0;
			clk_div_ff     <= 4'h0;
			ser_wake_en_ff <= 1'b0;
			cal_div_ff     <= CAL_DIV_RST;
			cmp_a_ff       <= 16'h0000;
			cmp_b_ff       <= 16'h0000;
			wake_mask_ff   <= '0;
		end else begin
			if (wr_fire && paddr == REG_CTRL) begin
				wdog_en_ff     <= pwdata[CTRL_WDOG_EN];
				clk_sel_ff     <= pwdata[CTRL_CLK_SEL];
				clk_div_ff     <= pwdata[CTRL_DIV_LSB+3:CTRL_DIV_LSB];
				ser_wake_en_ff <= pwdata[CTRL_SER_WAKE];
			end else if (to_evt) begin
				wdog_en_ff <= 1'b0;
			end
			if (wr_fire && paddr == REG_CAL_DIV) begin
				cal_div_ff <= pwdata[7:0];
			end
			if (wr_fire && paddr == REG_CMP_A) begin
				cmp_a_ff <= pwdata[15:0];
			end
			if (wr_fire && paddr == REG_CMP_B) begin
				cmp_b_ff <= pwdata[15:0];
			end
			if (wr_fire && paddr == REG_WAKE_MASK) begin
				wake_mask_ff <= pwdata[WAKE_GPIO_N-1:0];
			end
		end
	end

	// Timers keep running whatever the power mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_ff   <= 10'h000;
			sleep_cnt_ff <= 16'h0000;
			wdog_cnt_ff  <= '0;
			rst_cnt_ff   <= 5'h00;
			chip_reset   <= 1'b0;
		end else begin
			if (src_tick) begin
				pre_cnt_ff <= pre_cnt_ff + 10'h001;
			end
			if (pre_tick) begin
				sleep_cnt_ff <= nxt_sleep_cnt;
			end
			if ((wr_fire && paddr == REG_WDOG_KICK) || to_evt) begin
				wdog_cnt_ff <= '0;
			end else if (wd_step) begin
				wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
			end
			rst_cnt_ff <= to_evt ? RST_PULSE_CYC : (rst_cnt_ff != 5'h00 ? rst_cnt_ff - 5'h01 : 5'h00);
			chip_reset <= to_evt || (rst_cnt_ff > 5'h01);
		end
	end

	// Sticky flags: a new event beats a same-cycle clear
	assign stat_set[ST_CMP_A]      = cmp_a_evt;
	assign stat_set[ST_CMP_B]      = cmp_b_evt;
	assign stat_set[ST_WDOG_WARN]  = warn_evt;
	assign stat_set[ST_WDOG_RESET] = to_evt;

	assign wake_set[WK_CMP_A]   = cmp_a_evt;
	assign wake_set[WK_EXT_IRQ] = sync2_ff[18];
	assign wake_set[WK_DEBUG]   = sync2_ff[19];
	assign wake_set[WK_SERIAL]  = ser_wake;
	assign wake_set[WK_GPIO]    = gpio_chg;

	assign wake_any = |wake_set;
	assign in_wake  = (mode_ff == PM_SLEEP) || (mode_ff == PM_REG_UP) || (mode_ff == PM_RESTORE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_ff        <= 4'h0;
			wake_cause_ff  <= 5'h00;
			sleep_wake_req <= 1'b0;
		end else begin
			stat_ff <= (stat_ff & ~((wr_fire && paddr == REG_STATUS) ? pwdata[3:0] : 4'h0)) | stat_set;
			wake_cause_ff <= (wake_cause_ff & ~((wr_fire && paddr == REG_WAKE_CAUSE) ? pwdata[4:0] : 5'h00))
			                 | (in_wake ? wake_set : 5'h00);
			sleep_wake_req <= cmp_a_evt;
		end
	end

	assign cmp_a_irq     = stat_ff[ST_CMP_A];
	assign cmp_b_irq     = stat_ff[ST_CMP_B];
	assign wdog_warn_irq = stat_ff[ST_WDOG_WARN];

	// Power mode sequencer
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			PM_ACTIVE: begin
				if (wr_fire && paddr == REG_POWER && pwdata[PWR_DEEP]) begin
					nxt_mode = PM_SAVE;
				end else if (wr_fire && paddr == REG_POWER && pwdata[PWR_IDLE]) begin
					nxt_mode = PM_IDLE;
				end
			end
			PM_IDLE: begin
				if (cpu_irq || sync2_ff[19] || (|stat_ff[2:0])) begin
					nxt_mode = PM_ACTIVE;
				end
			end
			PM_SAVE: begin
				if (ctx_save_done) begin
					nxt_mode = PM_SLEEP;
				end
			end
			PM_SLEEP: begin
				if (wake_any) begin
					nxt_mode = PM_REG_UP;
				end
			end
			PM_REG_UP: begin
				if (sync2_ff[21]) begin
					nxt_mode = PM_RESTORE;
				end
			end
			PM_RESTORE: begin
				if (ctx_restore_done) begin
					nxt_mode = PM_ACTIVE;
				end
			end
			default: begin
				nxt_mode = PM_ACTIVE;
			end
		endcase
	end

	assign nxt_freeze = (nxt_mode != PM_ACTIVE) && (nxt_mode != PM_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff              <= PM_ACTIVE;
			cpu_halt             <= 1'b0;
			ctx_save_req         <= 1'b0;
			ctx_restore_req      <= 1'b0;
			core_reset_n         <= 1'b1;
			regulator_enable     <= 1'b1;
			regulator_output_pin <= 1'b1;
			gpio_frozen          <= 1'b0;
			gpio_out_pad         <= '0;
			serial_rx_enable     <= 1'b1;
		end else begin
			mode_ff              <= nxt_mode;
			cpu_halt             <= nxt_mode != PM_ACTIVE;
			ctx_save_req         <= nxt_mode == PM_SAVE;
			ctx_restore_req      <= nxt_mode == PM_RESTORE;
			core_reset_n         <= (nxt_mode != PM_SLEEP) && (nxt_mode != PM_REG_UP);
			regulator_enable     <= nxt_mode != PM_SLEEP;
			regulator_output_pin <= nxt_mode != PM_SLEEP;
			gpio_frozen          <= nxt_freeze;
			if (!nxt_freeze) begin
				gpio_out_pad <= gpio_out_core;
			end
			serial_rx_enable     <= !nxt_freeze;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_cal_src;
		cal_tick |-> $past(rc_tick);
	endproperty
	a_cal_src: assert property (p_cal_src) else $error("calibrated tick without rc edge");

	property p_wdog_en;
		$rose(chip_reset) |-> $past(wdog_en_ff, 1);
	endproperty
	a_wdog_en: assert property (p_wdog_en) else $error("chip reset while watchdog off");

	property p_timeout;
		to_evt |=> chip_reset [*8];
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout reset pulse short");

	property p_warn;
		wd_step && wdog_cnt_ff == WARN_LAST |=> stat_ff[ST_WDOG_WARN] && wdog_cnt_ff != WARN_LAST;
	endproperty
	a_warn: assert property (p_warn) else $error("warning flag missed");

	property p_wrap;
		pre_tick && sleep_cnt_ff == 16'hffff |=> sleep_cnt_ff == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("sleep counter did not wrap");

	property p_cmp_a;
		cmp_a_evt |=> cmp_a_irq && sleep_cnt_ff == cmp_a_ff && sleep_wake_req;
	endproperty
	a_cmp_a: assert property (p_cmp_a) else $error("compare a not flagged");

	property p_wake_src;
		sleep_wake_req |-> $past(cmp_a_evt);
	endproperty
	a_wake_src: assert property (p_wake_src) else $error("wake request without compare a");

	property p_freeze;
		mode_ff == PM_SLEEP |-> $stable(gpio_out_pad) && !regulator_enable && !core_reset_n;
	endproperty
	a_freeze: assert property (p_freeze) else $error("sleep outputs not held");

	property p_kick;
		wr_fire && paddr == REG_WDOG_KICK |=> wdog_cnt_ff == '0 ##1 !chip_reset;
	endproperty
	a_kick: assert property (p_kick) else $error("restart did not clear watchdog");

	property p_rx_off;
		in_wake |-> !serial_rx_enable;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("serial receiver on during wake");

	property p_log;
		$rose(chip_reset) |-> stat_ff[ST_WDOG_RESET];
	endproperty
	a_log: assert property (p_log) else $error("watchdog reset not logged");

	c_sleep_wake: cover property (mode_ff == PM_SLEEP ##1 mode_ff == PM_REG_UP);
	c_idle_exit:  cover property (mode_ff == PM_IDLE ##1 mode_ff == PM_ACTIVE);
	c_wdog_reset: cover property ($rose(chip_reset));
	c_cmp_b:      cover property (cmp_b_evt && !cmp_a_evt);
endmodule

// ==== verif/core_side_model.sv ====
// Behavioural core and regulator facing the power sequencer
// Assumes save/restore requests are levels held until done is seen
`timescale 1ns/1ns
module core_side_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic slow,
	input  wire logic ctx_save_req,
	input  wire logic ctx_restore_req,
	input  wire logic regulator_enable,
	output logic      ctx_save_done,
	output logic      ctx_restore_done,
	output logic      regulator_ready
);
	logic [3:0] ctx_cnt_ff;
	logic [3:0] reg_cnt_ff;
	logic [3:0] lat;
	logic       ctx_busy;
	// Slow mode stretches all three answers so the wait states are exercised
	assign lat = slow ? 4'h6 : 4'h1;
	assign ctx_busy = ctx_save_req | ctx_restore_req;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctx_cnt_ff <= 4'h0;
			reg_cnt_ff <= 4'h0;
			ctx_save_done <= 1'b0;
			ctx_restore_done <= 1'b0;
			regulator_ready <= 1'b0;
		end else begin
			ctx_cnt_ff <= ctx_busy ? ctx_cnt_ff + 4'(ctx_cnt_ff != 4'hf) : 4'h0;
			reg_cnt_ff <= regulator_enable ? reg_cnt_ff + 4'(reg_cnt_ff != 4'hf) : 4'h0;
			ctx_save_done <= ctx_save_req && ctx_cnt_ff >= lat;
			ctx_restore_done <= ctx_restore_req && ctx_cnt_ff >= lat;
			regulator_ready <= regulator_enable && reg_cnt_ff >= lat;
		end
	end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench of the always-on timer and power sequencer
// Assumes the APB slave answers without a fixed latency assumption
`timescale 1ns/1ns
module tb_top;
	import lowpower_pkg::*;
	localparam logic [11:0] RA [7] = '{REG_CTRL, REG_CAL_DIV, REG_CMP_A, REG_CMP_B, REG_WAKE_MASK, REG_POWER, 12'h0fc};
	localparam logic [31:0] RV [7] = '{32'h0, 32'h0a, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
	localparam logic [6:0]  CF [4] = '{7'h42, 7'h46, 7'h7e, 7'h40};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ev, slow, cpu_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic        rc_osc_in, low_freq_osc_input, regulator_ready, ctx_save_done, ctx_restore_done;
	logic [3:0]  wk_ff;
	logic [2:0]  osc_ff;
	logic [16:0] gpio_out_core, gpio_out_pad;
	logic        gpio_frozen, cmp_a_irq, cmp_b_irq, wdog_warn_irq, sleep_wake_req, chip_reset;
	logic        cpu_halt, ctx_save_req, ctx_restore_req, core_reset_n, regulator_enable;
	logic        regulator_output_pin, serial_rx_enable;
	logic [5:0]  watch;
	int          fails, cmp_count, wakes;
	assign watch = {cpu_halt, regulator_enable, chip_reset, wdog_warn_irq, cmp_b_irq, cmp_a_irq};
	aon_timer_power #(.WDOG_TIMEOUT_TICKS(40), .WDOG_WARN_TICKS(30)) i_aon_timer_power (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.rc_osc_in, .low_freq_osc_input, .ext_irq(wk_ff[0]), .debug_serial_port(wk_ff[1]),
		.serial_activity(wk_ff[2]), .regulator_ready, .gpio_in({16'h0, wk_ff[3]}), .gpio_out_core,
		.cpu_irq, .ctx_save_done, .ctx_restore_done, .gpio_out_pad, .gpio_frozen, .cmp_a_irq,
		.cmp_b_irq, .wdog_warn_irq, .sleep_wake_req, .chip_reset, .cpu_halt, .ctx_save_req,
		.ctx_restore_req, .core_reset_n, .regulator_enable, .regulator_output_pin, .serial_rx_enable);
	core_side_model i_core_side_model (.pclk, .presetn, .slow, .ctx_save_req, .ctx_restore_req,
		.regulator_enable, .ctx_save_done, .ctx_restore_done, .regulator_ready);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Both oscillators rise every 8 cycles, opposite phase
	always @(posedge pclk) begin
		osc_ff <= osc_ff + 3'h1;
		rc_osc_in <= osc_ff[2];
		low_freq_osc_input <= ~osc_ff[2];
		if (sleep_wake_req === 1'b1) wakes <= wakes + 1;
	end
	function int exp_delta(input int sel, input int n, input int cal);
		return 256 / ((sel ? 8 : 8 * cal) << (n > 10 ? 10 : n));
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) fails++;
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task waitv(input int i, input logic v, input int lim);
		int n;
		n = 0;
		while (watch[i] !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk(watch[i], v);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		summarize();
	end
	initial begin
		logic [31:0] c;
		logic [15:0] dd;
		logic [16:0] g, gn;
		int          w0;
		{fails, cmp_count, wakes} = '0;
		{presetn, psel, penable, pwrite, paddr, pwdata, slow, cpu_irq} = '0;
		{wk_ff, osc_ff, rc_osc_in, low_freq_osc_input, gpio_out_core} = '0;
		void'($urandom(71));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, RA[i], 32'h0);
			chk(rv, RV[i]);
			chk(ev, RA[i] == 12'h0fc);
		end
		$display("test reset done");
		apb(1'b1, REG_CAL_DIV, 32'h2);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, REG_CTRL, CF[i]);
			apb(1'b0, REG_SLEEP_CNT, 32'h0);
			c = rv;
			repeat (252) @(posedge pclk);
			apb(1'b0, REG_SLEEP_CNT, 32'h0);
			dd = rv[15:0] - c[15:0];
			chk((int'(dd) - exp_delta(CF[i][1], CF[i][5:2], 2)) inside {[-1:1]}, 1);
		end
		$display("test prescale done");
		apb(1'b1, REG_CTRL, 32'h42);
		apb(1'b1, REG_STATUS, 32'h3);
		apb(1'b0, REG_SLEEP_CNT, 32'h0);
		c = rv;
		apb(1'b1, REG_CMP_A, 16'(c + 6));
		apb(1'b1, REG_CMP_B, 16'(c + 10));
		w0 = wakes;
		waitv(0, 1'b1, 120);
		chk(cmp_b_irq, 1'b0);
		waitv(1, 1'b1, 120);
		chk(wakes - w0, 1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rv[1:0], 2'b11);
		apb(1'b1, REG_STATUS, 32'h3);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rv[1:0], 2'b00);
		$display("test compare done");
		apb(1'b1, REG_POWER, 32'h1);
		apb(1'b0, REG_POWER, 32'h0);
		chk(rv, 32'h2);
		chk(cpu_halt, 1'b1);
		cpu_irq <= 1'b1;
		@(posedge pclk);
		cpu_irq <= 1'b0;
		waitv(5, 1'b0, 10);
		$display("test idle done");
		apb(1'b1, REG_WAKE_MASK, 32'h1);
		for (int i = 0; i < 4; i++) begin
			g = 17'($urandom);
			gn = ~g;
			gpio_out_core <= g;
			slow <= i[0];
			apb(1'b1, REG_WAKE_CAUSE, 32'h1f);
			apb(1'b1, REG_POWER, 32'h2);
			waitv(4, 1'b0, 60);
			chk({gpio_frozen, core_reset_n, serial_rx_enable, regulator_output_pin}, 4'b1000);
			chk({ctx_save_req, ctx_restore_req, cpu_halt}, 3'b001);
			chk(gpio_out_pad, g);
			gpio_out_core <= gn;
			wk_ff <= 4'(1 << i);
			waitv(5, 1'b0, 120);
			wk_ff <= 4'h0;
			chk(regulator_enable, 1'b1);
			apb(1'b0, REG_WAKE_CAUSE, 32'h0);
			chk(rv[WK_EXT_IRQ + i], 1'b1);
			chk(gpio_out_pad, gn);
		end
		$display("test deep sleep done");
		apb(1'b1, REG_CTRL, 32'h43);
		repeat (200) @(posedge pclk);
		apb(1'b1, REG_WDOG_KICK, 32'h0);
		repeat (200) @(posedge pclk);
		chk({wdog_warn_irq, chip_reset}, 2'b00);
		waitv(2, 1'b1, 80);
		chk(chip_reset, 1'b0);
		waitv(3, 1'b1, 120);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rv[3:2], 2'b11);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rv[0], 1'b0);
		$display("test watchdog done");
		summarize();
	end
endmodule
